// >>> shared/fcs_params.svh
// Constants for the flash checksum scanner
// How it works
// - Scan starts three cycles after enable write
// - Checksum width comes from a fuse
// - Startup scan holds CPU; failure keeps it
// - Pass leaves enable, section, pass flag set
// - Startup fail hangs CPU, pass flag reads zero
// - Scan owns flash and stalls the CPU
// - Each word fetch takes three cycles
// - CCITT sixteen and IEEE thirty-two polynomials
// - Bytes from zero, MSB first, per byte
// - Sixteen-bit checksum presets to all ones
// - Pass only when trailing checksum matches
// - Failure clears the pass flag
// - Failure with enable raises sticky NMI
// - NMI ignores global interrupt enable
// - Sleep halts scan, wake resumes it
// - Sleep in delay defers start, holds CPU
// - Debugger memory access halts, later restarts
// - Busy stays set while debugger holds scan
// - Debugger busy writes cancel or request scan
// - Section and NMI enable locked while busy
// - Debugger pass writes; NMI blocks writes
// - Section codes: flash, boot+app, boot, reserved
// - Enable stays set; rewrite restarts, zero ignored
// - Reset strobe clears all but failure enable next cycle
// - Pass flag resets to one
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
// Register word indices, byte address is four times these
`define FCS_IDX_CONTROL_FIRST 2'h0
`define FCS_IDX_CONTROL_SECOND 2'h1
`define FCS_IDX_STATUS 2'h2
// Field positions
`define FCS_CF_ENABLE 0
`define FCS_CF_FAIL_IRQ_EN 1
`define FCS_CF_RESET 7
`define FCS_STAT_BUSY 0
`define FCS_STAT_OK 1
`define FCS_OK_RESET 1'h1
// Section codes and fuse code for no startup scan
`define FCS_SEC_FLASH 2'h0
`define FCS_SEC_BOOT_APP 2'h1
`define FCS_SEC_BOOT 2'h2
`define FCS_FUSE_NO_SCAN 2'h3
// Timing and arithmetic
`define FCS_START_DELAY 2'h3
`define FCS_WORD_BYTES 2
`define FCS_TAIL16 1
`define FCS_TAIL32 3
`define FCS_PRESET16 32'h0000_FFFF
`define FCS_PRESET32 32'hFFFF_FFFF
`define FCS_POLY16 32'h0000_1021
`define FCS_POLY32 32'h04C1_1DB7
`endif

// >>> shared/fcs_pkg.sv
// Types for the flash checksum scanner
package fcs_pkg;
	// One-hot scan sequencer states
	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_DELAY = 7'h02,
		ST_PEND  = 7'h04,
		ST_FETCH = 7'h08,
		ST_LO    = 7'h10,
		ST_HI    = 7'h20,
		ST_DONE  = 7'h40
	} fcs_state_e;
	// Status pair as seen by the debugger
	typedef struct packed {
		logic	ok;
		logic	busy;
	} fcs_stat_s;
endpackage : fcs_pkg

// >>> design/fcs_flash_crc_scanner.sv
// Flash checksum scanner with APB registers
`include "fcs_params.svh"

module fcs_flash_crc_scanner #(
	parameter int ADDR_W = 15	// Flash byte address width
) (
	input	wire logic			pclk,
	input	wire logic			presetn,
	input	wire logic			psel,
	input	wire logic			penable,
	input	wire logic			pwrite,
	input	wire logic [11:0]		paddr,
	input	wire logic [31:0]		pwdata,
	output	logic [31:0]			prdata,
	output	logic				pready,
	output	logic				pslverr,
	input	wire logic			crc32_fuse,
	input	wire logic [1:0]		startup_scan_fuse,
	input	wire logic [ADDR_W-1:0]		boot_section_last,
	input	wire logic [ADDR_W-1:0]		app_code_last,
	input	wire logic [ADDR_W-1:0]		flash_last_byte,
	output	logic				flash_req,
	output	logic [ADDR_W-1:0]		flash_addr,
	input	wire logic [15:0]		flash_rdata,
	input	wire logic			flash_valid,
	input	wire logic			sleep_in,
	input	wire logic			dbg_mem_access,
	input	wire logic			dbg_int_access,
	input	wire logic			dbg_disconnect,
	input	wire logic			dbg_busy_we,
	input	wire logic			dbg_ok_we,
	input	wire fcs_pkg::fcs_stat_s	dbg_stat_wdata,
	output	fcs_pkg::fcs_stat_s		dbg_stat,
	output	logic				cpu_stall,
	output	logic				cpu_start_hold,
	output	logic				nmi_req
);

	// Sequencer state
	fcs_pkg::fcs_state_e	state_r;
	fcs_pkg::fcs_state_e	state_nxt;
	// Software visible bits
	logic			enable_r;
	logic			fail_irq_en_r;
	logic			busy_r;
	logic			ok_r;
	logic			ok_nxt;
	logic [1:0]		section_select_r;
	// Internal control
	logic			nmi_r;		// Sticky until system reset
	logic			rst_pend_r;	// Reset strobe, acts one cycle late
	logic			dbg_hold_r;	// Debugger keeps scan parked
	logic			crc32_r;	// Fuse copy taken at release
	logic			boot_r;		// Low only in first cycle
	logic			sleep_dly_r;	// Slept during start delay
	logic [1:0]		dly_r;
	// Datapath
	logic [ADDR_W-1:0]	addr_r;
	logic [15:0]		data_r;
	logic [31:0]		crc_r;
	logic [31:0]		stored_r;
	// Registered bus answer and the other registered outputs
	logic [31:0]		prdata_r;
	logic			pready_r;
	logic			pslverr_r;
	logic			flash_req_r;
	logic			cpu_stall_r;
	logic			hold_r;
	fcs_pkg::fcs_stat_s	dbg_stat_r;

	// One byte through the MSB-first shift register
	function automatic logic [31:0] crc_step(
		input logic [31:0] c,
		input logic [7:0]  b,
		input logic        w
	);
		logic [31:0] v;
		logic        fb;
		v = c;
		for (int i = 7; i >= 0; i--)
		begin
			fb = (w ? v[31] : v[15]) ^ b[i];
			v = {v[30:0], 1'b0} ^ (fb ? (w ? `FCS_POLY32 : `FCS_POLY16) : 32'h0000_0000);
		end
		// Narrow mode keeps only sixteen bits
		if (!w)
			v[31:16] = 16'h0000;
		return v;
	endfunction : crc_step

	// State decodes
	wire st_idle  = state_r == fcs_pkg::ST_IDLE;
	wire st_delay = state_r == fcs_pkg::ST_DELAY;
	wire st_pend  = state_r == fcs_pkg::ST_PEND;
	wire st_fetch = state_r == fcs_pkg::ST_FETCH;
	wire st_lo    = state_r == fcs_pkg::ST_LO;
	wire st_hi    = state_r == fcs_pkg::ST_HI;
	wire st_done  = state_r == fcs_pkg::ST_DONE;

	// APB decode; writes land only on the access edge
	wire [1:0] idx    = paddr[3:2];
	wire       hit    = (paddr[11:4] == '0) && (paddr[1:0] == '0)
			   && (idx != 2'h3);
	wire       acc    = psel & penable & pready_r;
	wire       wr     = acc & pwrite & hit & ~nmi_r;
	wire       wr_cf  = wr & (idx == `FCS_IDX_CONTROL_FIRST);
	wire       wr_cs  = wr & (idx == `FCS_IDX_CONTROL_SECOND);

	// Strobe refused mid-scan when failure interrupt is armed
	wire strobe_ok = wr_cf & pwdata[`FCS_CF_RESET] & (~fail_irq_en_r | ~busy_r);
	// Enable rewrite starts a scan; zero does nothing
	wire start_sw  = wr_cf & pwdata[`FCS_CF_ENABLE] & ~busy_r;
	// Debugger status writes, blocked once NMI fired
	wire dbg_busy1 = dbg_busy_we & dbg_stat_wdata.busy & ~nmi_r;
	wire dbg_busy0 = dbg_busy_we & ~dbg_stat_wdata.busy & ~nmi_r;
	wire dbg_ok_w  = dbg_ok_we & ~nmi_r;
	wire dbg_go    = dbg_int_access | dbg_disconnect;
	// Mid-scan memory access parks the scan for a restart
	wire dbg_park  = dbg_mem_access & busy_r & ~st_idle & ~st_done;
	// First cycle after release with a startup scan fused in
	wire boot_go   = ~boot_r & (startup_scan_fuse != `FCS_FUSE_NO_SCAN);
	// Sleep and debugger both freeze progress
	wire run_ok    = ~sleep_in & ~dbg_hold_r;

	// Section end; reserved code falls back to whole flash
	wire [ADDR_W-1:0] sec_last =
		(section_select_r == `FCS_SEC_BOOT) ? boot_section_last :
		(section_select_r == `FCS_SEC_BOOT_APP) ? app_code_last :
		flash_last_byte;
	// Trailing checksum bytes are kept out of the sum
	wire [ADDR_W-1:0] tail     = crc32_r ? ADDR_W'(`FCS_TAIL32) : ADDR_W'(`FCS_TAIL16);
	wire [ADDR_W-1:0] cs_first = sec_last - tail;
	wire [ADDR_W-1:0] cur_addr = {addr_r[ADDR_W-1:1], st_hi};
	wire [7:0]        cur_byte = st_hi ? data_r[15:8] : data_r[7:0];
	wire              in_cs    = cur_addr >= cs_first;
	wire              last_b   = cur_addr == sec_last;
	// Compare computed and stored sums at their width
	wire              match    = crc32_r ? (crc_r == stored_r)
				     : (crc_r[15:0] == stored_r[15:0]);

	// Next pass flag; reset strobe outranks everything
	assign ok_nxt = rst_pend_r ? `FCS_OK_RESET :
			dbg_ok_w ? dbg_stat_wdata.ok :
			st_done ? match : ok_r;

	// Sequencer next state
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			fcs_pkg::ST_IDLE:
				state_nxt = fcs_pkg::ST_IDLE;
			// Count only awake cycles
			fcs_pkg::ST_DELAY:
				if (run_ok && dly_r == 2'h1)
					state_nxt = fcs_pkg::ST_PEND;
			// Fresh start once allowed
			fcs_pkg::ST_PEND:
				if (run_ok)
					state_nxt = fcs_pkg::ST_FETCH;
			// Wait for the flash to answer
			fcs_pkg::ST_FETCH:
				if (flash_req_r && flash_valid)
					state_nxt = fcs_pkg::ST_LO;
			fcs_pkg::ST_LO:
				if (run_ok)
					state_nxt = fcs_pkg::ST_HI;
			fcs_pkg::ST_HI:
				if (run_ok)
					state_nxt = last_b ? fcs_pkg::ST_DONE : fcs_pkg::ST_FETCH;
			fcs_pkg::ST_DONE:
				state_nxt = fcs_pkg::ST_IDLE;
			default:
				state_nxt = fcs_pkg::ST_IDLE;
		endcase
		// Overrides, weakest first
		if (start_sw)
			state_nxt = fcs_pkg::ST_DELAY;
		if (boot_go || dbg_busy1 || dbg_park)
			state_nxt = fcs_pkg::ST_PEND;
		if (dbg_busy0 || rst_pend_r)
			state_nxt = fcs_pkg::ST_IDLE;
	end

	// Sequencer and fetch path
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r     <= fcs_pkg::ST_IDLE;
			dly_r       <= `FCS_START_DELAY;
			addr_r      <= '0;
			data_r      <= 16'h0000;
			flash_req_r <= 1'b0;
		end
		else
		begin
			state_r     <= state_nxt;
			dly_r       <= (st_delay && run_ok) ? 2'(dly_r - 2'h1) : `FCS_START_DELAY;
			// Request held until the flash answers
			flash_req_r <= state_nxt == fcs_pkg::ST_FETCH;
			if (st_pend)
				addr_r <= '0;
			else if (st_hi && run_ok && !last_b)
				addr_r <= ADDR_W'(addr_r + ADDR_W'(`FCS_WORD_BYTES));
			if (flash_req_r && flash_valid)
				data_r <= flash_rdata;
		end
	end

	// Checksum and stored sum capture
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			crc_r    <= 32'h0000_0000;
			stored_r <= 32'h0000_0000;
		end
		else if (st_pend)
		begin
			crc_r    <= crc32_r ? `FCS_PRESET32 : `FCS_PRESET16;
			stored_r <= 32'h0000_0000;
		end
		else if ((st_lo || st_hi) && run_ok)
		begin
			// Wide sum arrives low byte first, narrow high first
			if (in_cs)
				stored_r <= crc32_r ? {cur_byte, stored_r[31:8]}
					    : {stored_r[23:0], cur_byte};
			else
				crc_r <= crc_step(crc_r, cur_byte, crc32_r);
		end
	end

	// Fuse capture one edge after release, never under reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			boot_r  <= 1'b0;
			crc32_r <= 1'b0;
		end
		else
		begin
			boot_r <= 1'b1;
			if (!boot_r)
				crc32_r <= crc32_fuse;
		end
	end

	// Control and status registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable_r         <= 1'b0;
			busy_r           <= 1'b0;
			section_select_r <= `FCS_SEC_FLASH;
		end
		else if (rst_pend_r)
		begin
			// Strobe leaves the failure enable alone
			enable_r         <= 1'b0;
			busy_r           <= 1'b0;
			section_select_r <= `FCS_SEC_FLASH;
		end
		else
		begin
			if (wr_cs && !busy_r)
				section_select_r <= pwdata[1:0];
			if (start_sw || boot_go)
			begin
				enable_r <= 1'b1;
				busy_r   <= 1'b1;
			end
			if (boot_go)
				section_select_r <= startup_scan_fuse;
			if (dbg_busy1)
				busy_r <= 1'b1;
			// Debugger hold keeps busy set; a fresh debugger request outlives the finish
			if (dbg_busy0 || (st_done && !dbg_busy1))
				busy_r <= 1'b0;
		end
	end

	// Pass flag, failure enable and the sticky NMI
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ok_r          <= `FCS_OK_RESET;
			fail_irq_en_r <= 1'b0;
			nmi_r         <= 1'b0;
		end
		else
		begin
			ok_r <= ok_nxt;
			// Settable only when idle, cleared only by reset
			if (wr_cf && pwdata[`FCS_CF_FAIL_IRQ_EN] && !busy_r)
				fail_irq_en_r <= 1'b1;
			// Falling pass flag fires; no global mask applies
			if (ok_r && !ok_nxt && fail_irq_en_r)
				nmi_r <= 1'b1;
		end
	end

	// Strobe delay, debugger hold and sleep tracking
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rst_pend_r  <= 1'b0;
			dbg_hold_r  <= 1'b0;
			sleep_dly_r <= 1'b0;
		end
		else
		begin
			rst_pend_r  <= strobe_ok;
			// New access wins over a release in the same cycle
			dbg_hold_r  <= dbg_mem_access | (dbg_hold_r & ~dbg_go);
			sleep_dly_r <= st_delay & (sleep_dly_r | sleep_in);
		end
	end

	// CPU side controls; hold starts high until fuses seen
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cpu_stall_r <= 1'b0;
			hold_r      <= 1'b1;
		end
		else
		begin
			// Delay lets the CPU run unless it slept there
			cpu_stall_r <= (busy_r & ~st_delay) | (st_delay & sleep_dly_r);
			if (!boot_r)
				hold_r <= boot_go;
			else if (st_done && match)
				hold_r <= 1'b0;
		end
	end

	// Register read values, reserved bits zero, strobe reads zero
	wire [31:0] rd_cf  = (32'(fail_irq_en_r) << `FCS_CF_FAIL_IRQ_EN)
			   | (32'(enable_r) << `FCS_CF_ENABLE);
	wire [31:0] rd_cs  = 32'(section_select_r);
	wire [31:0] rd_st  = (32'(ok_r) << `FCS_STAT_OK)
			   | (32'(busy_r) << `FCS_STAT_BUSY);
	wire [31:0] rd_val = (idx == `FCS_IDX_CONTROL_FIRST) ? rd_cf :
			     (idx == `FCS_IDX_CONTROL_SECOND) ? rd_cs : rd_st;
	wire        setup  = psel & ~penable;

	// Bus answer prepared in setup, shown in the access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r   <= 32'h0000_0000;
			pready_r   <= 1'b0;
			pslverr_r  <= 1'b0;
			dbg_stat_r <= '0;
		end
		else
		begin
			pready_r   <= setup;
			pslverr_r  <= setup & ~hit;
			prdata_r   <= (setup && !pwrite && hit) ? rd_val : 32'h0000_0000;
			dbg_stat_r <= '{ok: ok_r, busy: busy_r};
		end
	end

	// Outputs straight from flip-flops
	assign prdata         = prdata_r;
	assign pready         = pready_r;
	assign pslverr        = pslverr_r;
	assign flash_req      = flash_req_r;
	assign flash_addr     = addr_r;
	assign dbg_stat       = dbg_stat_r;
	assign cpu_stall      = cpu_stall_r;
	assign cpu_start_hold = hold_r;
	assign nmi_req        = nmi_r;

	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// No interfering event in a cycle
	wire quiet = run_ok & ~rst_pend_r & ~dbg_busy_we & ~dbg_mem_access;

	property p_start_delay;
		$rose(st_delay) ##0 quiet [*3] |=> st_pend;
	endproperty
	a_start_delay: assert property (p_start_delay)
		else $error("scan not pending three cycles after enable");

	property p_fetch;
		(flash_req_r && flash_valid && quiet) ##1 quiet |=> st_hi;
	endproperty
	a_fetch: assert property (p_fetch)
		else $error("word fetch did not finish in three cycles");

	property p_req_hold;
		flash_req_r && !flash_valid && quiet |=> flash_req_r && $stable(flash_addr);
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("flash request dropped before answer");

	property p_stall;
		st_fetch || st_lo || st_hi |=> cpu_stall;
	endproperty
	a_stall: assert property (p_stall)
		else $error("cpu not stalled during scan");

	property p_fail;
		st_done && !match && !rst_pend_r && !dbg_ok_we && !dbg_busy_we |=> !ok_r && !busy_r;
	endproperty
	a_fail: assert property (p_fail)
		else $error("failed scan left pass flag set");

	property p_pass;
		st_done && match && !rst_pend_r && !dbg_ok_we && !dbg_busy_we
			|=> ok_r && !busy_r && enable_r;
	endproperty
	a_pass: assert property (p_pass)
		else $error("passed scan left wrong status");

	property p_nmi_keep;
		nmi_r |=> nmi_r && nmi_req;
	endproperty
	a_nmi_keep: assert property (p_nmi_keep)
		else $error("nmi request dropped");

	property p_nmi_cause;
		$rose(nmi_r) |-> $past(fail_irq_en_r) && $past(ok_r) && !ok_r;
	endproperty
	a_nmi_cause: assert property (p_nmi_cause)
		else $error("nmi without falling pass flag");

	property p_sleep;
		sleep_in && (st_lo || st_hi) && !rst_pend_r && !dbg_busy_we && !dbg_mem_access
			|=> $stable(crc_r) && $stable(state_r);
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("scan advanced during sleep");

	property p_lock;
		busy_r && wr_cs && !rst_pend_r |=> $stable(section_select_r);
	endproperty
	a_lock: assert property (p_lock)
		else $error("section changed while busy");

	property p_strobe;
		strobe_ok |=> ##1 !busy_r && !enable_r && ok_r;
	endproperty
	a_strobe: assert property (p_strobe)
		else $error("reset strobe did not clear registers");

	property p_hang;
		boot_r && hold_r && st_done && !match |=> cpu_start_hold;
	endproperty
	a_hang: assert property (p_hang)
		else $error("cpu released after failed startup scan");

	property p_dbg_park;
		dbg_hold_r |-> !(st_fetch || st_lo || st_hi);
	endproperty
	a_dbg_park: assert property (p_dbg_park)
		else $error("scan ran while debugger held it");

	c_pass: cover property (st_done && match);
	c_fail: cover property (st_done && !match);
	c_nmi: cover property ($rose(nmi_r));
	c_restart: cover property (dbg_hold_r ##1 !dbg_hold_r && st_pend);

endmodule : fcs_flash_crc_scanner

// >>> test/fcs_flash_model.sv
// Behavioural model of the flash read port facing the scanner
module fcs_flash_model (
	input	wire logic		pclk,
	input	wire logic		presetn,
	input	wire logic		flash_req,
	input	wire logic [14:0]	flash_addr,
	input	wire logic [3:0]	lag,
	output	logic [15:0]		flash_rdata,
	output	logic			flash_valid
);
	logic [7:0]	mem [0:63];	// Flash image, loaded by the bench
	logic [3:0]	cnt_r;		// Cycles waited on this request
	logic		done_r;		// Word already answered
	// One answer per request, after lag cycles
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_r <= 4'h0;
			done_r <= 1'h0;
			flash_valid <= 1'h0;
			flash_rdata <= 16'h0000;
		end
		else
		begin
			flash_valid <= 1'h0;
			// Stale data toggles so a late sample cannot pass by luck
			flash_rdata <= ~flash_rdata;
			if (!flash_req)
			begin
				cnt_r <= 4'h0;
				done_r <= 1'h0;
			end
			else if (!done_r && cnt_r >= lag)
			begin
				flash_valid <= 1'h1;
				done_r <= 1'h1;
				flash_rdata <= {mem[{flash_addr[5:1], 1'h1}], mem[{flash_addr[5:1], 1'h0}]};
			end
			else if (!done_r)
				cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule : fcs_flash_model

// >>> test/fcs_flash_crc_scanner_tb.sv
// Self-checking bench for the flash checksum scanner
module fcs_flash_crc_scanner_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic		w32;	// Wide checksum fuse
		logic [1:0]	sec;	// Section code
		logic		bad;	// Corrupt first byte
		logic		irq;	// Arm failure interrupt
		logic [3:0]	lag;	// Flash answer delay
	} fcs_row_s;
	// Ordinary scans, one per row
	fcs_row_s	rows [0:7] = '{'{0, 0, 0, 0, 0}, '{0, 1, 0, 0, 3}, '{0, 2, 1, 0, 0},
		'{0, 3, 0, 0, 1}, '{1, 0, 0, 0, 2}, '{1, 1, 1, 1, 0}, '{1, 2, 0, 0, 0},
		'{0, 1, 1, 1, 2}};
	// Last byte per section code; reserved scans the whole flash
	logic [14:0]	sec_last [0:3] = '{15'h003F, 15'h001F, 15'h000F, 15'h003F};
	logic		pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0]	paddr = 12'h000;
	logic [31:0]	pwdata = 32'h0000_0000;
	logic [31:0]	prdata;
	logic		pready, pslverr, flash_req, flash_valid, cpu_stall, cpu_start_hold, nmi_req;
	logic		crc32_fuse = 1'h0, sleep_in = 1'h0, dbg_mem_access = 1'h0;
	logic		dbg_int_access = 1'h0, dbg_disconnect = 1'h0, dbg_busy_we = 1'h0, dbg_ok_we = 1'h0;
	logic [1:0]	startup_scan_fuse = 2'h3;
	logic [14:0]	flash_addr;
	logic [15:0]	flash_rdata;
	logic [3:0]	lag = 4'h0;
	fcs_pkg::fcs_stat_s	dbg_stat, dbg_stat_wdata = 2'h0;
	logic [31:0]	rd;	// Last read word
	logic		er;	// Last error response
	int		err_count = 0, compares = 0, cyc = 0;

	always #2.5 pclk = ~pclk;

	fcs_flash_crc_scanner dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .crc32_fuse, .startup_scan_fuse,
		.boot_section_last(15'h000F), .app_code_last(15'h001F), .flash_last_byte(15'h003F),
		.flash_req, .flash_addr, .flash_rdata, .flash_valid, .sleep_in, .dbg_mem_access,
		.dbg_int_access, .dbg_disconnect, .dbg_busy_we, .dbg_ok_we, .dbg_stat_wdata,
		.dbg_stat, .cpu_stall, .cpu_start_hold, .nmi_req);
	fcs_flash_model mdl_u (.pclk, .presetn, .flash_req, .flash_addr, .lag, .flash_rdata,
		.flash_valid);

	// Verdict and end of run
	task automatic summarize;
		if (err_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize
	// Compare register words
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected word at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk_reg
	// Compare single pins
	task automatic chk_pin(input logic got, input logic exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected pin at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk_pin
	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// Poll status until busy clears
	task automatic wait_idle;
		do apb(1'h0, 12'h008, 32'h0000_0000); while (rd[0] !== 1'h0);
	endtask : wait_idle
	// Wait for a word fetch to show
	task automatic wait_req;
		do @(posedge pclk); while (flash_req !== 1'h1);
	endtask : wait_req
	// Reference checksum of bytes 0..n-1, MSB first, no final inversion
	function automatic logic [31:0] crc(input logic w32, input int n);
		logic [31:0] c;
		logic fb;
		c = w32 ? 32'hFFFF_FFFF : 32'h0000_FFFF;
		for (int i = 0; i < n; i++)
			for (int b = 7; b >= 0; b--)
			begin
				fb = (w32 ? c[31] : c[15]) ^ mdl_u.mem[i][b];
				c = {c[30:0], 1'h0} ^ (fb ? (w32 ? 32'h04C1_1DB7 : 32'h0000_1021) : 32'h0);
				if (!w32)
					c[31:16] = 16'h0000;
			end
		return c;
	endfunction : crc
	// Reset with fuses; every section gets its checksum, outermost last
	task automatic rst(input logic w32, input logic [1:0] fz, input logic bad);
		logic [31:0] c;
		@(posedge pclk);
		presetn <= 1'h0;
		crc32_fuse <= w32;
		startup_scan_fuse <= fz;
		for (int i = 0; i < 64; i++)
			mdl_u.mem[i] = 8'(i * 37 + 5);
		for (int s = 2; s >= 0; s--)
		begin
			c = crc(w32, int'(sec_last[s]) + 1 - (w32 ? 4 : 2));
			if (w32)
				{mdl_u.mem[sec_last[s]], mdl_u.mem[sec_last[s] - 1], mdl_u.mem[sec_last[s] - 2],
					mdl_u.mem[sec_last[s] - 3]} = c;
			else
				{mdl_u.mem[sec_last[s] - 1], mdl_u.mem[sec_last[s]]} = c[15:0];
		end
		mdl_u.mem[0] ^= {7'h0, bad};
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
	endtask : rst

	// Hang guard
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_count++;
			summarize();
		end
	end

	initial
	begin
		// Table of ordinary scans
		foreach (rows[k])
		begin
			rst(rows[k].w32, 2'h3, rows[k].bad);
			lag <= rows[k].lag;
			if (rows[k].irq)
				apb(1'h1, 12'h000, 32'h0000_0002);
			apb(1'h1, 12'h004, {30'h0, rows[k].sec});
			apb(1'h1, 12'h000, 32'h0000_0001);
			wait_idle();
			chk_reg(rd, {30'h0, !rows[k].bad, 1'h0});
			apb(1'h0, 12'h000, 32'h0000_0000);
			chk_reg(rd, {30'h0, rows[k].irq, 1'h1});
			apb(1'h0, 12'h004, 32'h0000_0000);
			chk_reg(rd, {30'h0, rows[k].sec});
			chk_pin(nmi_req, rows[k].bad & rows[k].irq);
		end
		// Reset values, unmapped word, start delay, busy lock
		rst(1'h0, 2'h3, 1'h0);
		apb(1'h0, 12'h008, 32'h0000_0000);
		chk_reg(rd, 32'h0000_0002);
		chk_pin(cpu_start_hold, 1'h0);
		apb(1'h0, 12'h00C, 32'h0000_0000);
		chk_pin(er, 1'h1);
		apb(1'h1, 12'h004, 32'h0000_0002);
		apb(1'h1, 12'h000, 32'h0000_0001);
		repeat (3)
		begin
			chk_pin(flash_req | cpu_stall, 1'h0);
			@(posedge pclk);
		end
		wait_req();
		chk_pin(cpu_stall, 1'h1);
		apb(1'h1, 12'h004, 32'h0000_0001);
		apb(1'h0, 12'h004, 32'h0000_0000);
		chk_reg(rd, 32'h0000_0002);
		wait_idle();
		// Sleep in the start delay, then in mid-scan
		apb(1'h1, 12'h000, 32'h0000_0001);
		sleep_in <= 1'h1;
		repeat (10) @(posedge pclk);
		chk_pin(flash_req, 1'h0);
		chk_pin(cpu_stall, 1'h1);
		sleep_in <= 1'h0;
		wait_req();
		sleep_in <= 1'h1;
		repeat (10) @(posedge pclk);
		chk_pin(flash_req, 1'h0);
		chk_pin(dbg_stat.busy, 1'h1);
		sleep_in <= 1'h0;
		wait_idle();
		chk_reg(rd, 32'h0000_0002);
		// Debugger park, then release by disconnect
		apb(1'h1, 12'h000, 32'h0000_0001);
		wait_req();
		dbg_mem_access <= 1'h1;
		@(posedge pclk);
		dbg_mem_access <= 1'h0;
		repeat (10) @(posedge pclk);
		chk_pin(flash_req, 1'h0);
		chk_pin(dbg_stat.busy, 1'h1);
		dbg_disconnect <= 1'h1;
		@(posedge pclk);
		dbg_disconnect <= 1'h0;
		wait_idle();
		chk_reg(rd, 32'h0000_0002);
		// Debugger cancel, then a requested check held until permitted
		apb(1'h1, 12'h000, 32'h0000_0001);
		wait_req();
		dbg_stat_wdata <= 2'h0;
		dbg_busy_we <= 1'h1;
		@(posedge pclk);
		dbg_busy_we <= 1'h0;
		repeat (3) @(posedge pclk);
		chk_pin(dbg_stat.busy, 1'h0);
		dbg_mem_access <= 1'h1;
		dbg_stat_wdata <= 2'h1;
		@(posedge pclk);
		dbg_mem_access <= 1'h0;
		dbg_busy_we <= 1'h1;
		@(posedge pclk);
		dbg_busy_we <= 1'h0;
		repeat (5) @(posedge pclk);
		chk_pin(flash_req, 1'h0);
		dbg_int_access <= 1'h1;
		@(posedge pclk);
		dbg_int_access <= 1'h0;
		wait_req();
		wait_idle();
		chk_reg(rd, 32'h0000_0002);
		// Debugger writes of the pass flag
		dbg_stat_wdata <= 2'h0;
		dbg_ok_we <= 1'h1;
		@(posedge pclk);
		dbg_ok_we <= 1'h0;
		apb(1'h0, 12'h008, 32'h0000_0000);
		chk_reg(rd, 32'h0000_0000);
		dbg_stat_wdata <= 2'h2;
		dbg_ok_we <= 1'h1;
		@(posedge pclk);
		dbg_ok_we <= 1'h0;
		apb(1'h0, 12'h008, 32'h0000_0000);
		chk_reg(rd, 32'h0000_0002);
		// Reset strobe in mid-scan
		apb(1'h1, 12'h000, 32'h0000_0001);
		wait_req();
		apb(1'h1, 12'h000, 32'h0000_0080);
		apb(1'h0, 12'h008, 32'h0000_0000);
		chk_reg(rd, 32'h0000_0002);
		apb(1'h0, 12'h004, 32'h0000_0000);
		chk_reg(rd, 32'h0000_0000);
		// Failure interrupt is sticky and locks writes
		rst(1'h1, 2'h3, 1'h1);
		apb(1'h1, 12'h000, 32'h0000_0002);
		apb(1'h1, 12'h000, 32'h0000_0001);
		wait_idle();
		apb(1'h1, 12'h004, 32'h0000_0001);
		apb(1'h0, 12'h004, 32'h0000_0000);
		chk_reg(rd, 32'h0000_0000);
		chk_pin(nmi_req, 1'h1);
		// Start-up scans: pass frees the CPU, failure keeps it held
		rst(1'h1, 2'h2, 1'h0);
		wait_idle();
		repeat (2) @(posedge pclk);
		chk_pin(cpu_start_hold, 1'h0);
		apb(1'h0, 12'h000, 32'h0000_0000);
		chk_reg(rd, 32'h0000_0001);
		apb(1'h0, 12'h004, 32'h0000_0000);
		chk_reg(rd, 32'h0000_0002);
		rst(1'h0, 2'h1, 1'h1);
		wait_idle();
		repeat (2) @(posedge pclk);
		chk_pin(cpu_start_hold, 1'h1);
		chk_reg(rd, 32'h0000_0000);
		summarize();
	end
endmodule : fcs_flash_crc_scanner_tb
